// [rtl/dspc_core.sv]
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// RL1 - 32-bit sum register holds results, feeds arithmetic, shifts and rotates.
// RL2 - unsigned 16-bit address unit updates pointer registers for indirect access.
// RL3 - eight 16-bit pointers; pointer select picks the active one.
// RL4 - pointer zero is step value and compare value for the selected pointer.
// RL5 - global request held during global access until READY; space up to 32K.
// RL6 - carry kept in status, fed back, tested by conditions, used in shifts.
// RL7 - main unit does 32-bit op per cycle on shifter data and sum.
// RL8 - block zero in data space when placement bit is 0, else program.
// RL9 - blocks one and two at 0300-03FF and 0060-007F in data space.
// RL10 - blocks zero and one hold 256 words, block two 32 words.
// RL11 - direct address is page pointer joined with seven instruction bits.
// RL12 - page pointer changes only by load-status and load-page operations.
// RL13 - global size register sets size of global data space.
// RL14 - seven interrupt flags latched; mask register enables each individually.
// RL15 - 32 traps reachable by hardware requests or software.
// RL16 - input shifter shifts 16-bit data left 0 to 16 in one cycle.
// RL17 - multiplier makes 32-bit product, signed or unsigned, in one cycle.
// RL18 - micro return store keeps next fetch address during data sequencing.
// RL19 - output shifter shifts sum 0 to 7 and drives high or low half.
// RL20 - next-fetch register holds address driven on next cycle.
// RL21 - current-fetch register holds program address while memory work is pending.
// RL22 - fetch counter increments next-fetch address for sequential addresses.
// RL23 - sequencer decodes operations and evaluates branch conditions.
// RL24 - product shifter: left 0, 1, 4 or right 6 with no extra cycle.
// RL25 - product register captures each 16 by 16 product.
// RL26 - multiplier operand register also gives dynamic shift counts.
module dspc_core
	import dspc_pkg::*;
#(
	parameter int GLOBAL_MAX_PAGES = GLOBAL_PAGES_MAX
) (
	input  wire logic               CORE_CLK,
	input  wire logic               RSTN,
	input  wire logic               WB_CYC_I,
	input  wire logic               WB_STB_I,
	input  wire logic               WB_WE_I,
	input  wire logic [7:0]         WB_ADR_I,
	input  wire logic [3:0]         WB_SEL_I,
	input  wire logic [31:0]        WB_DAT_I,
	output wire logic [31:0]        WB_DAT_O,
	output wire logic               WB_ACK_O,
	input  wire logic [NUM_IRQ-1:0] INT_REQ,
	input  wire logic               GLOBAL_READY,
	input  wire logic [15:0]        GLOBAL_RDATA,
	output wire logic               GLOBAL_REQ,
	output wire logic               GLOBAL_WE,
	output wire logic [15:0]        GLOBAL_ADDR,
	output wire logic [15:0]        WRITE_DATA_BUS,
	output wire logic [15:0]        PROG_ADDR,
	output wire logic               TRAP_REQ,
	output wire logic [4:0]         TRAP_NUM
);

	if (GLOBAL_MAX_PAGES < 1 || GLOBAL_MAX_PAGES > GLOBAL_PAGES_MAX) begin
		$error("GLOBAL_MAX_PAGES out of range");
	end

	dspc_state_t  s;
	dspc_state_t  n;
	dspc_wb_req_t wb;
	logic         wr_fire;
	logic         cmd_fire;
	dspc_op_t     op;
	logic [11:0]  arg;

	// byte-lane merge for register writes
	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// input shifter, count clipped to 16
	function automatic logic [31:0] ishift(input logic [15:0] d, input logic [4:0] cnt, input logic sx);
		logic [31:0] e;
		logic [4:0]  c;
		e = sx ? {{16{d[15]}}, d} : {16'h0, d};
		c = (cnt > 5'(ISHIFT_MAX)) ? 5'(ISHIFT_MAX) : cnt;
		return e << c;
	endfunction

	// product shifter modes
	function automatic logic [31:0] pshift(input logic [31:0] p, input logic [1:0] m);
		unique case (m)
			2'h0: return p;
			2'h1: return p << 1;
			2'h2: return p << 4;
			2'h3: return 32'($signed(p) >>> 6);
		endcase
	endfunction

	// 16x16 multiply, signed or unsigned
	function automatic logic [31:0] mul(input logic [15:0] a, input logic [15:0] b, input logic sg);
		if (sg) begin
			return $signed({{16{a[15]}}, a}) * $signed({{16{b[15]}}, b});
		end
		return {16'h0, a} * {16'h0, b};
	endfunction

	// indirect address arithmetic, unsigned 16-bit
	function automatic logic [15:0] indirect_address_unit(input logic [15:0] p, input logic [15:0] step, input logic [1:0] m);
		unique case (m)
			2'h0: return p;
			2'h1: return p + 16'h0001;
			2'h2: return p - 16'h0001;
			2'h3: return p + step;
		endcase
	endfunction

	// global space is the top gsize pages of data space
	function automatic logic is_global(input logic [15:0] a, input logic [7:0] gs);
		return (gs != 8'h00) && ({1'b0, a[15:8]} >= (9'h100 - {1'b0, gs}));
	endfunction

	// branch condition evaluation
	function automatic logic cond_ok(input logic [1:0] c, input dspc_state_t st);
		unique case (c)
			2'h0: return 1'b1;
			2'h1: return st.carry;
			2'h2: return st.cmp;
			2'h3: return st.sum == 32'h0;
		endcase
	endfunction

	// bus request bundle and command decode
	assign wb       = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};
	assign wr_fire  = wb.cyc & wb.stb & wb.we & s.ack;
	assign cmd_fire = wr_fire && wb.adr == REG_CMD && wb.sel[1] && !s.busy;
	assign op       = dspc_op_t'(wb.dat[15:12]);
	assign arg      = wb.dat[11:0];

	// next-state logic
	always_comb begin
		logic [32:0]        t;
		logic [15:0]        da;
		logic [31:0]        ov;
		logic [NUM_IRQ-1:0] clr;
		logic [NUM_IRQ-1:0] pend;
		logic               taken;
		t     = 33'h0;
		da    = 16'h0;
		ov    = 32'h0;
		clr   = '0;
		pend  = '0;
		taken = 1'b0;
		n     = s;
		// wishbone: ack one cycle after the strobe, read data with it
		n.ack   = wb.cyc & wb.stb & ~s.ack;
		n.dat_o = 32'h0;
		if (wb.cyc & wb.stb & ~s.ack) begin
			unique case (wb.adr)
				REG_OPERAND: n.dat_o = {16'h0, s.opnd};
				REG_SUM:     n.dat_o = s.sum;
				REG_PROD:    n.dat_o = s.prod;
				REG_STATUS:  n.dat_o = {16'h0, s.psel, s.place, s.cmp, s.busy, s.carry, s.page};
				REG_MULOP:   n.dat_o = {16'h0, s.mulop};
				REG_PTR:     n.dat_o = {15'h0, s.dmode, s.ptr[s.psel]};
				REG_IFLAG:   n.dat_o = {25'h0, s.iflag};
				REG_IMASK:   n.dat_o = {25'h0, s.imask};
				REG_GSIZE:   n.dat_o = {24'h0, s.gsize};
				REG_FETCH:   n.dat_o = {s.cfa, s.nfa};
				REG_MRS:     n.dat_o = {s.instr, s.mrs};
				REG_DBUS:    n.dat_o = {s.rdata, s.wdata};
				REG_TRAP:    n.dat_o = {26'h0, s.trap_req, s.trap_num};
				default:     n.dat_o = 32'h0;
			endcase
		end
		// register writes
		if (wr_fire) begin
			unique case (wb.adr)
				REG_OPERAND: n.opnd = 16'(wb_merge({16'h0, s.opnd}, wb.dat, wb.sel));
				REG_MULOP:   n.mulop = 16'(wb_merge({16'h0, s.mulop}, wb.dat, wb.sel));
				REG_IMASK:   n.imask = NUM_IRQ'(wb_merge({25'h0, s.imask}, wb.dat, wb.sel)); // [RL14]
				REG_IFLAG:   clr = wb.sel[0] ? wb.dat[NUM_IRQ-1:0] : '0;
				REG_GSIZE:   if (wb.sel[0]) begin
					n.gsize = (wb.dat[7:0] > 8'(GLOBAL_MAX_PAGES)) ? 8'(GLOBAL_MAX_PAGES) : wb.dat[7:0]; // [RL13] [RL5]
				end
				REG_TRAP:    if (wb.sel[0]) begin
					n.trap_req = 1'b0;
				end
				default:     ;
			endcase
		end
		// global access completes when the far side is ready
		if (s.busy && GLOBAL_READY) begin
			n.busy    = 1'b0; // [RL5]
			n.glb_req = 1'b0;
			n.glb_we  = 1'b0;
			if (!s.glb_we) begin
				n.rdata = GLOBAL_RDATA;
			end
		end
		// command execution, one operation per cycle
		if (cmd_fire) begin
			unique case (op)
				OP_LOAD_SUM: n.sum = ishift(s.opnd, arg[5] ? s.mulop[4:0] : arg[4:0], arg[6]); // [RL16] [RL26]
				OP_ADD: begin
					t = {1'b0, s.sum} + {1'b0, ishift(s.opnd, arg[5] ? s.mulop[4:0] : arg[4:0], arg[6])}
						+ {32'h0, arg[7] & s.carry}; // [RL7] [RL6]
					n.sum   = t[31:0]; // [RL1]
					n.carry = t[32];
				end
				OP_SUB: begin
					t = {1'b0, s.sum} - {1'b0, ishift(s.opnd, arg[5] ? s.mulop[4:0] : arg[4:0], arg[6])}; // [RL7]
					n.sum   = t[31:0];
					n.carry = ~t[32]; // no borrow reads as carry set
				end
				OP_ADD_PROD: begin
					t = {1'b0, s.sum} + {1'b0, pshift(s.prod, arg[1:0])}; // [RL24] [RL7]
					n.sum   = t[31:0];
					n.carry = t[32];
				end
				OP_MULT: n.prod = mul(s.mulop, s.opnd, arg[0]); // [RL17] [RL25]
				OP_SHIFT: begin
					unique case (arg[1:0])
						2'h0: {n.carry, n.sum} = {s.sum, 1'b0}; // [RL1] [RL6]
						2'h1: {n.sum, n.carry} = {1'b0, s.sum};
						2'h2: {n.carry, n.sum} = {s.sum, s.carry};
						2'h3: {n.sum, n.carry} = {s.carry, s.sum};
					endcase
				end
				OP_STORE_OUT: begin
					ov      = s.sum << arg[2:0]; // [RL19]
					n.wdata = arg[3] ? ov[31:16] : ov[15:0];
				end
				OP_MEM_WRITE, OP_MEM_READ: begin
					da = arg[7] ? s.ptr[s.psel] : {s.page, arg[6:0]}; // [RL11] [RL3]
					if (arg[7]) begin
						n.ptr[s.psel] = indirect_address_unit(s.ptr[s.psel], s.ptr[0], arg[9:8]); // [RL2] [RL4]
					end
					if (is_global(da, s.gsize)) begin
						n.busy     = 1'b1; // [RL5]
						n.glb_req  = 1'b1;
						n.glb_we   = op == OP_MEM_WRITE;
						n.glb_addr = da;
					end else if (da[15:8] == BLK1_BASE[15:8]) begin // [RL9] [RL10]
						if (op == OP_MEM_WRITE) n.blk1[da[7:0]] = s.wdata;
						else n.rdata = s.blk1[da[7:0]];
					end else if (da[15:5] == BLK2_BASE[15:5]) begin
						if (op == OP_MEM_WRITE) n.blk2[da[4:0]] = s.wdata;
						else n.rdata = s.blk2[da[4:0]];
					end else if (!s.place && da[15:8] == BLK0_DATA_BASE[15:8]) begin // [RL8]
						if (op == OP_MEM_WRITE) n.blk0[da[7:0]] = s.wdata;
						else n.rdata = s.blk0[da[7:0]];
					end else if (op == OP_MEM_READ) begin
						n.rdata = 16'h0;
					end
				end
				OP_LOAD_PAGE: n.page = arg[8:0]; // [RL12]
				OP_LOAD_STATUS: begin
					n.page  = s.opnd[ST_PAGE_LSB +: 9]; // [RL12]
					n.carry = s.opnd[ST_CARRY];
					n.place = s.opnd[ST_PLACE];
					n.psel  = s.opnd[ST_PSEL_LSB +: 3]; // [RL3]
				end
				OP_SET_POINTER: n.ptr[arg[2:0]] = s.opnd; // [RL3]
				OP_COMPARE: n.cmp = s.ptr[s.psel] == s.ptr[0]; // [RL4]
				OP_TRAP: ;
				OP_FETCH: begin
					n.cfa = s.nfa; // [RL20]
					if (arg[3]) begin
						n.mrs   = s.nfa + 16'h0001; // [RL18]
						n.nfa   = s.opnd;
						n.dmode = 1'b1;
					end else if (arg[4]) begin
						n.nfa   = s.mrs;
						n.dmode = 1'b0;
					end else if (arg[2] && cond_ok(arg[1:0], s)) begin
						n.nfa = s.opnd; // [RL23] [RL6]
					end else begin
						n.nfa = s.nfa + 16'h0001; // [RL22]
					end
					n.instr = (s.place && s.nfa[15:8] == BLK0_PROG_BASE[15:8]) ? s.blk0[s.nfa[7:0]] : 16'h0; // [RL8]
				end
				default: ;
			endcase
		end
		// interrupt flags and trap selection; a new request beats a clear
		pend = s.iflag & s.imask;
		if (!s.trap_req && pend != '0) begin
			for (int i = NUM_IRQ - 1; i >= 0; i--) begin
				if (pend[i]) begin
					n.trap_num = 5'(i + 1); // [RL15]
				end
			end
			clr        = clr | (pend & -pend); // keep a software clear of the same cycle
			n.trap_req = 1'b1;
			taken      = 1'b1;
		end
		if (!taken && !s.trap_req && cmd_fire && op == OP_TRAP) begin
			n.trap_req = 1'b1; // [RL15]
			n.trap_num = arg[4:0];
		end
		n.iflag = (s.iflag & ~clr) | INT_REQ; // [RL14]
	end

	// state register
	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			s <= STATE_RESET;
		end else begin
			s <= n;
		end
	end

	assign WB_DAT_O       = s.dat_o;
	assign WB_ACK_O       = s.ack;
	assign GLOBAL_REQ     = s.glb_req;
	assign GLOBAL_WE      = s.glb_we;
	assign GLOBAL_ADDR    = s.glb_addr;
	assign WRITE_DATA_BUS = s.wdata;
	assign PROG_ADDR      = s.cfa; // [RL21]
	assign TRAP_REQ       = s.trap_req;
	assign TRAP_NUM       = s.trap_num;

	// checks
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	AST_ACK_ONCE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");
	AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
	AST_PAGE_SRC: assert property ($changed(s.page) |-> $past(cmd_fire) && // [RL12]
		($past(op) == OP_LOAD_PAGE || $past(op) == OP_LOAD_STATUS)) else $error("page changed by other op");
	AST_MULT: assert property (cmd_fire && op == OP_MULT && !arg[0] |=> // [RL17]
		s.prod == {16'h0, $past(s.mulop)} * {16'h0, $past(s.opnd)}) else $error("bad product");
	AST_GREQ_HOLD: assert property (GLOBAL_REQ && !GLOBAL_READY |=> GLOBAL_REQ) else $error("request dropped"); // [RL5]
	AST_GREQ_DONE: assert property (GLOBAL_REQ && GLOBAL_READY |=> !GLOBAL_REQ && !s.busy) // [RL5]
		else $error("request stuck");
	AST_FETCH_HOLD: assert property (s.busy |=> $stable(PROG_ADDR)) else $error("fetch address moved"); // [RL21]
	AST_FETCH_STEP: assert property (cmd_fire && op == OP_FETCH && arg[4:2] == 3'h0 |=> // [RL22]
		PROG_ADDR == $past(s.nfa) && s.nfa == $past(s.nfa) + 16'h0001) else $error("bad sequential fetch");
	AST_IFLAG_SET: assert property (INT_REQ != '0 |=> (s.iflag & $past(INT_REQ)) == $past(INT_REQ)) // [RL14]
		else $error("interrupt request lost");

	COV_GLOBAL_WAIT: cover property (GLOBAL_REQ && !GLOBAL_READY ##1 GLOBAL_REQ && GLOBAL_READY);
	COV_MULT_SIGNED: cover property (cmd_fire && op == OP_MULT && arg[0]);
	COV_HW_TRAP: cover property (!TRAP_REQ && (s.iflag & s.imask) != '0 ##1 TRAP_REQ);
	COV_BRANCH: cover property (cmd_fire && op == OP_FETCH && arg[2] && s.carry);
endmodule

// [rtl/dspc_pkg.sv]
package dspc_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] REG_CMD     = 8'h00;
	localparam logic [7:0] REG_OPERAND = 8'h04;
	localparam logic [7:0] REG_SUM     = 8'h08;
	localparam logic [7:0] REG_PROD    = 8'h0C;
	localparam logic [7:0] REG_STATUS  = 8'h10;
	localparam logic [7:0] REG_MULOP   = 8'h14;
	localparam logic [7:0] REG_PTR     = 8'h18;
	localparam logic [7:0] REG_IFLAG   = 8'h1C;
	localparam logic [7:0] REG_IMASK   = 8'h20;
	localparam logic [7:0] REG_GSIZE   = 8'h24;
	localparam logic [7:0] REG_FETCH   = 8'h28;
	localparam logic [7:0] REG_MRS     = 8'h2C;
	localparam logic [7:0] REG_DBUS    = 8'h30;
	localparam logic [7:0] REG_TRAP    = 8'h34;

	// status word one field positions
	localparam int ST_PAGE_LSB = 0;
	localparam int ST_CARRY    = 9;
	localparam int ST_BUSY     = 10;
	localparam int ST_CMP      = 11;
	localparam int ST_PLACE    = 12;
	localparam int ST_PSEL_LSB = 13;

	// ram block placement
	localparam logic [15:0] BLK0_DATA_BASE = 16'h0200;
	localparam logic [15:0] BLK0_PROG_BASE = 16'hFF00;
	localparam logic [15:0] BLK1_BASE      = 16'h0300;
	localparam logic [15:0] BLK2_BASE      = 16'h0060;
	localparam int BLK0_WORDS = 256;
	localparam int BLK1_WORDS = 256;
	localparam int BLK2_WORDS = 32;

	// limits
	localparam int ISHIFT_MAX       = 16;
	localparam int GLOBAL_PAGES_MAX = 128;
	localparam int NUM_IRQ          = 7;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_LOAD_SUM = 4'h1, OP_ADD = 4'h2, OP_SUB = 4'h3,
		OP_ADD_PROD = 4'h4, OP_MULT = 4'h5, OP_SHIFT = 4'h6, OP_STORE_OUT = 4'h7,
		OP_MEM_WRITE = 4'h8, OP_MEM_READ = 4'h9, OP_LOAD_PAGE = 4'hA, OP_LOAD_STATUS = 4'hB,
		OP_SET_POINTER = 4'hC, OP_COMPARE = 4'hD, OP_TRAP = 4'hE, OP_FETCH = 4'hF
	} dspc_op_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} dspc_wb_req_t;

	typedef struct packed {
		logic [31:0]                   sum;
		logic                          carry;
		logic [31:0]                   prod;
		logic [15:0]                   opnd;
		logic [15:0]                   mulop;
		logic [7:0][15:0]              ptr;
		logic [2:0]                    psel;
		logic [8:0]                    page;
		logic                          place;
		logic                          cmp;
		logic [7:0]                    gsize;
		logic [NUM_IRQ-1:0]            iflag;
		logic [NUM_IRQ-1:0]            imask;
		logic                          trap_req;
		logic [4:0]                    trap_num;
		logic [15:0]                   nfa;
		logic [15:0]                   cfa;
		logic [15:0]                   mrs;
		logic                          dmode;
		logic [15:0]                   instr;
		logic                          busy;
		logic                          glb_req;
		logic                          glb_we;
		logic [15:0]                   glb_addr;
		logic [15:0]                   wdata;
		logic [15:0]                   rdata;
		logic [BLK0_WORDS-1:0][15:0]   blk0;
		logic [BLK1_WORDS-1:0][15:0]   blk1;
		logic [BLK2_WORDS-1:0][15:0]   blk2;
		logic                          ack;
		logic [31:0]                   dat_o;
	} dspc_state_t;

	localparam dspc_state_t STATE_RESET = '0;
endpackage

// [test/dsp_core_datapath_tb.sv]
`timescale 1ns/1ps
module dsp_core_datapath_tb;
	import dspc_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [6:0]  irq = 7'h00;
	logic [3:0]  glb_wait = 4'h0;
	logic [31:0] wb_rd, wb_q;
	logic        wb_ack, g_ready, g_req, g_we, trap_req;
	logic [15:0] g_rdata, g_addr, wbus, paddr;
	logic [4:0]  trap_num;
	int          err_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	dspc_core uut (.CORE_CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(wb_rd), .WB_ACK_O(wb_ack),
		.INT_REQ(irq), .GLOBAL_READY(g_ready), .GLOBAL_RDATA(g_rdata), .GLOBAL_REQ(g_req),
		.GLOBAL_WE(g_we), .GLOBAL_ADDR(g_addr), .WRITE_DATA_BUS(wbus), .PROG_ADDR(paddr),
		.TRAP_REQ(trap_req), .TRAP_NUM(trap_num));
	dspc_glb_mem gmem (.clk(clk), .rstn(rstn), .wait_cycles(glb_wait), .req(g_req), .we(g_we),
		.addr(g_addr), .wdata(wbus), .ready(g_ready), .rdata(g_rdata));

	// clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		@(posedge clk iff wb_ack === 1'b1);
		wb_q = wb_rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(wb_q & m, e);
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 40; i++) begin
			wb(1'b0, REG_STATUS, 32'h0);
			if (wb_q[ST_BUSY] === 1'b0) return;
		end
		err_count++;
		final_report();
	endtask

	task automatic cmd(input logic [3:0] op, input logic [11:0] arg);
		wb(1'b1, REG_CMD, {16'h0, op, arg});
		wait_idle();
	endtask

	task automatic t_reset();
		rchk(REG_SUM, '1, 32'h0);
		rchk(REG_STATUS, '1, 32'h0);
		rchk(8'h3C, '1, 32'h0);
		wb(1'b1, REG_SUM, 32'h1234);
		rchk(REG_SUM, '1, 32'h0);
	endtask

	task automatic t_arith();
		wb(1'b1, REG_OPERAND, 32'hFFFF);
		cmd(OP_LOAD_SUM, 12'h010);
		rchk(REG_SUM, '1, 32'hFFFF0000);
		cmd(OP_ADD, 12'h010);
		rchk(REG_SUM, '1, 32'hFFFE0000);
		rchk(REG_STATUS, 32'h200, 32'h200);
		cmd(OP_ADD, 12'h080);
		rchk(REG_SUM, '1, 32'hFFFF0000);
		cmd(OP_SHIFT, 12'h002);
		rchk(REG_SUM, '1, 32'hFFFE0000);
		rchk(REG_STATUS, 32'h200, 32'h200);
		cmd(OP_LOAD_SUM, 12'h044);
		rchk(REG_SUM, '1, 32'hFFFFFFF0);
	endtask

	task automatic t_mult();
		wb(1'b1, REG_MULOP, 32'hFFFE);
		wb(1'b1, REG_OPERAND, 32'h3);
		cmd(OP_MULT, 12'h001);
		rchk(REG_PROD, '1, 32'hFFFFFFFA);
		cmd(OP_MULT, 12'h000);
		rchk(REG_PROD, '1, 32'h0002FFFA);
		cmd(OP_LOAD_SUM, 12'h020);
		rchk(REG_SUM, '1, 32'h00030000);
		cmd(OP_LOAD_SUM, 12'h000);
		cmd(OP_ADD_PROD, 12'h003);
		rchk(REG_SUM, '1, 32'h00000C02);
		cmd(OP_STORE_OUT, 12'h00F);
		rchk(REG_DBUS, 32'hFFFF, 32'h0006);
		cmd(OP_STORE_OUT, 12'h000);
		chk({16'h0, wbus}, 32'h0C02);
	endtask

	// direct accesses into each ram block and a hole
	task automatic t_mem();
		cmd(OP_LOAD_PAGE, 12'h006);
		rchk(REG_STATUS, 32'h1FF, 32'h6);
		cmd(OP_MEM_WRITE, 12'h005);
		cmd(OP_LOAD_PAGE, 12'h000);
		cmd(OP_MEM_WRITE, 12'h060);
		cmd(OP_LOAD_PAGE, 12'h006);
		cmd(OP_MEM_READ, 12'h005);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h0C020000);
		cmd(OP_LOAD_PAGE, 12'h004);
		cmd(OP_MEM_WRITE, 12'h07F);
		cmd(OP_MEM_READ, 12'h07F);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h0C020000);
		cmd(OP_STORE_OUT, 12'h00F);
		cmd(OP_LOAD_PAGE, 12'h000);
		cmd(OP_MEM_WRITE, 12'h07F);
		cmd(OP_MEM_READ, 12'h060);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h0C020000);
		cmd(OP_MEM_READ, 12'h07F);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h00060000);
		cmd(OP_LOAD_PAGE, 12'h008);
		cmd(OP_MEM_READ, 12'h000);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h0);
	endtask

	task automatic t_ptr();
		wb(1'b1, REG_OPERAND, 32'h2);
		cmd(OP_SET_POINTER, 12'h000);
		wb(1'b1, REG_OPERAND, 32'h0305);
		cmd(OP_SET_POINTER, 12'h001);
		wb(1'b1, REG_OPERAND, 32'h2006);
		cmd(OP_LOAD_STATUS, 12'h000);
		cmd(OP_MEM_READ, 12'h380);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h0C020000);
		rchk(REG_PTR, 32'hFFFF, 32'h0307);
		wb(1'b1, REG_OPERAND, 32'h2);
		cmd(OP_SET_POINTER, 12'h001);
		cmd(OP_COMPARE, 12'h000);
		rchk(REG_STATUS, '1, 32'h2806);
	endtask

	// slow global write, then prompt global read back
	task automatic t_global();
		wb(1'b1, REG_GSIZE, 32'h1);
		rchk(REG_GSIZE, 32'hFF, 32'h1);
		cmd(OP_LOAD_PAGE, 12'h1FF);
		glb_wait <= 4'h3;
		wb(1'b1, REG_CMD, 32'h8001);
		@(negedge clk);
		chk({14'h0, g_req, g_we, g_addr}, 32'h3FF81);
		wait_idle();
		chk({31'h0, g_req}, 32'h0);
		glb_wait <= 4'h0;
		cmd(OP_MEM_READ, 12'h001);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h00060000);
	endtask

	task automatic t_irq();
		wb(1'b1, REG_IMASK, 32'h4);
		irq <= 7'h04;
		@(posedge clk);
		irq <= 7'h00;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			if (trap_req === 1'b1) break;
		end
		chk({27'h0, trap_num}, 32'h3);
		rchk(REG_IFLAG, 32'h7F, 32'h0);
		rchk(REG_TRAP, 32'h3F, 32'h23);
		wb(1'b1, REG_TRAP, 32'h0);
		rchk(REG_TRAP, 32'h20, 32'h0);
		irq <= 7'h01;
		@(posedge clk);
		irq <= 7'h00;
		rchk(REG_IFLAG, 32'h7F, 32'h1);
		chk({31'h0, trap_req}, 32'h0);
		wb(1'b1, REG_IFLAG, 32'h1);
		rchk(REG_IFLAG, 32'h7F, 32'h0);
		cmd(OP_TRAP, 12'h01F);
		rchk(REG_TRAP, 32'h3F, 32'h3F);
		wb(1'b1, REG_TRAP, 32'h0);
	endtask

	task automatic t_fetch();
		cmd(OP_FETCH, 12'h000);
		rchk(REG_FETCH, '1, 32'h00000001);
		cmd(OP_FETCH, 12'h000);
		rchk(REG_FETCH, '1, 32'h00010002);
		wb(1'b1, REG_OPERAND, 32'h40);
		cmd(OP_FETCH, 12'h004);
		rchk(REG_FETCH, '1, 32'h00020040);
		chk({16'h0, paddr}, 32'h2);
		cmd(OP_FETCH, 12'h005);
		rchk(REG_FETCH, '1, 32'h00400041);
		wb(1'b1, REG_OPERAND, 32'h100);
		cmd(OP_FETCH, 12'h008);
		rchk(REG_FETCH, '1, 32'h00410100);
		rchk(REG_MRS, 32'hFFFF, 32'h42);
		rchk(REG_PTR, 32'h10000, 32'h10000);
		cmd(OP_FETCH, 12'h010);
		rchk(REG_FETCH, '1, 32'h01000042);
		// block zero moved to program space: gone from data, fetched as a program word
		wb(1'b1, REG_OPERAND, 32'h1004);
		cmd(OP_LOAD_STATUS, 12'h000);
		cmd(OP_MEM_READ, 12'h07F);
		rchk(REG_DBUS, 32'hFFFF0000, 32'h0);
		wb(1'b1, REG_OPERAND, 32'hFF7F);
		cmd(OP_FETCH, 12'h004);
		cmd(OP_FETCH, 12'h000);
		rchk(REG_MRS, 32'hFFFF0000, 32'h0C020000);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_arith();
		t_mult();
		t_mem();
		t_ptr();
		t_global();
		t_irq();
		t_fetch();
		final_report();
	end
endmodule

// [test/dspc_glb_mem.sv]
`timescale 1ns/1ps
// global data memory model, answers a request after a set number of wait cycles
module dspc_glb_mem (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  wait_cycles,
	input  wire logic        req,
	input  wire logic        we,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	output logic             ready,
	output logic [15:0]      rdata
);
	logic [15:0] mem [256];
	logic [3:0]  cnt;

	// one ready pulse per access; a released data bus toggles every cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ready <= 1'b0;
			cnt <= 4'h0;
			rdata <= 16'h5A5A;
		end else if (req && !ready && cnt >= wait_cycles) begin
			ready <= 1'b1;
			cnt <= 4'h0;
			rdata <= mem[addr[7:0]];
			if (we) begin
				mem[addr[7:0]] <= wdata;
			end
		end else begin
			ready <= 1'b0;
			cnt <= req ? cnt + 4'h1 : 4'h0;
			rdata <= ~rdata;
		end
	end
endmodule
